// [fpc_pkg.sv]
// Constants, field layouts and state types for the floppy and parallel
// port configuration register bank.
// Assumes one 100 MHz clock and a hard reset that is asynchronous.

package fpc_pkg;

	// ------------------------------------------------------------------
	// Logical devices and register indices
	// ------------------------------------------------------------------
	localparam logic [7:0] LDN_FLOPPY       = 8'h00;
	localparam logic [7:0] LDN_PARALLEL     = 8'h03;
	localparam logic [7:0] IDX_FDC_MODE     = 8'hF0;
	localparam logic [7:0] IDX_FDC_OPTION   = 8'hF1;
	localparam logic [7:0] IDX_FDC_TYPES    = 8'hF2;
	localparam logic [7:0] IDX_FDC_RSVD     = 8'hF3;
	localparam logic [7:0] IDX_DRIVE0       = 8'hF4;
	localparam logic [7:0] IDX_DRIVE1       = 8'hF5;
	localparam logic [7:0] IDX_PP_MODE      = 8'hF0;
	localparam logic [7:0] IDX_PP_SHARE     = 8'hF1;

	// ------------------------------------------------------------------
	// Reset values and writable bit masks
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_FDC_MODE     = 8'h0E;
	localparam logic [7:0] RST_FDC_OPTION   = 8'h00;
	localparam logic [7:0] RST_FDC_TYPES    = 8'hFF;
	localparam logic [7:0] RST_DRIVE        = 8'h00;
	localparam logic [7:0] RST_PP_MODE      = 8'h3C;
	localparam logic [7:0] RST_PP_SHARE     = 8'h00;
	localparam logic [7:0] RST_INDEX        = 8'h00;
	localparam logic [7:0] MASK_FDC_MODE    = 8'hDF;
	localparam logic [7:0] MASK_DRIVE       = 8'h5B;
	localparam logic [7:0] MASK_PP_SHARE    = 8'h03;
	localparam logic [7:0] MASK_ALL         = 8'hFF;
	localparam logic [7:0] READ_ZERO        = 8'h00;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int FM_ENHANCED   = 0;
	localparam int FM_NONBURST   = 1;
	localparam int FM_IF_LO      = 2;
	localparam int FM_PUSH_PULL  = 6;
	localparam int FM_TRISTATE   = 7;
	localparam int FO_FORCE_WP   = 0;
	localparam int FO_DENS_LO    = 2;
	localparam int DP_TYPE_LO    = 0;
	localparam int DP_RATE_LO    = 3;
	localparam int DP_PRECOMP    = 6;
	localparam int PM_MODE_LO    = 0;
	localparam int PM_THRESH_LO  = 3;
	localparam int PM_IRQ_PULSE  = 7;
	localparam int PS_SHARE_LO   = 0;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] DENS_FORCE_ONE   = 2'h2;
	localparam logic [1:0] DENS_FORCE_ZERO  = 2'h3;
	localparam logic [2:0] PPM_PRINTER      = 3'h4;
	localparam logic [2:0] PPM_SPP          = 3'h0;
	localparam logic [2:0] PPM_EPP19        = 3'h1;
	localparam logic [2:0] PPM_EPP17        = 3'h5;
	localparam logic [2:0] PPM_ECP          = 3'h2;
	localparam logic [2:0] PPM_ECP_EPP19    = 3'h3;
	localparam logic [2:0] PPM_ECP_EPP17    = 3'h7;
	localparam logic [2:0] ECR_FIFO         = 3'h2;
	localparam logic [2:0] ECR_ECP          = 3'h3;
	localparam logic [2:0] ECR_TEST         = 3'h6;
	localparam logic [1:0] SHARE_NONE       = 2'h0;
	localparam logic [1:0] SHARE_DRIVE1     = 2'h1;
	localparam logic [1:0] SHARE_BOTH       = 2'h2;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS    = 10000;
	localparam int IRQ_PULSE_NS     = 100;
	localparam int IRQ_PULSE_CYC    = (IRQ_PULSE_NS * 1000) / CLK_PERIOD_PS;
	localparam int FDC_PIN_W        = 8;
	localparam int SYNC_W           = 3;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [0:0] {
		IRQ_IDLE  = 1'b0,
		IRQ_PULSE = 1'b1
	} fpc_irq_state_t;

	typedef struct packed {
		logic [SYNC_W-1:0] first;
		logic [SYNC_W-1:0] second;
	} fpc_sync_t;

	typedef struct packed {
		logic [7:0] fdc_mode;
		logic [7:0] fdc_option;
		logic [7:0] fdc_types;
		logic [7:0] drive0;
		logic [7:0] drive1;
		logic [7:0] pp_mode;
		logic [7:0] pp_share;
	} fpc_regs_t;

	typedef struct packed {
		logic [7:0]           index;
		fpc_regs_t            regs;
		logic [7:0]           rdata;
		logic                 ack_n_prev;
		logic                 core_irq_prev;
		fpc_irq_state_t       irq_state;
		logic [7:0]           irq_count;
		logic                 irq_out;
		logic                 irq_oe_n;
		logic [FDC_PIN_W-1:0] pad_out;
		logic [FDC_PIN_W-1:0] pad_oe_n;
		logic [FDC_PIN_W-1:0] port_fdc_out;
		logic                 port_fdc_oe_n;
		logic                 core_wp_n;
		logic                 density_out;
	} fpc_state_t;

endpackage : fpc_pkg

// [fpc_sync.sv]
// Two-stage synchroniser for pin inputs entering the clock domain.
// Assumes inputs are asynchronous levels; outputs lag by two edges.
`timescale 1ns/1ps

module fpc_sync (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [fpc_pkg::SYNC_W-1:0] async_in,
	output logic      [fpc_pkg::SYNC_W-1:0] sync_out
);

	fpc_pkg::fpc_sync_t state_reg;
	fpc_pkg::fpc_sync_t state_next;

	// First stage feeds only the second stage
	always_comb begin
		state_next        = state_reg;
		state_next.first  = async_in;
		state_next.second = state_reg.first;
	end

	// Inputs idle high, so reset to ones
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{first: '1, second: '1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.second;

endmodule : fpc_sync

// [fpc_config_regs.sv]
// Vendor configuration register bank for the floppy and parallel port
// logical devices, with the pin muxing and interrupt shaping they steer.
// Assumes the config port address is decoded upstream, the logical
// device number comes from the global registers, and core signals are
// on this clock.
`timescale 1ns/1ps

module fpc_config_regs (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          soft_reset,
	input  wire logic                          cfg_sel,
	input  wire logic                          cfg_addr,
	input  wire logic                          cfg_wr,
	input  wire logic                          cfg_rd,
	input  wire logic [7:0]                    cfg_wdata,
	input  wire logic [7:0]                    cfg_ldn,
	output logic      [7:0]                    cfg_rdata,
	output logic                               enhanced_mode,
	output logic                               burst_dma_en,
	output logic      [1:0]                    host_if_mode,
	output logic      [7:0]                    drive_type_code,
	output logic      [1:0]                    drive0_type_select,
	output logic      [1:0]                    drive0_rate_table,
	output logic                               drive0_precomp_disable,
	output logic      [1:0]                    drive1_type_select,
	output logic      [1:0]                    drive1_rate_table,
	output logic                               drive1_precomp_disable,
	output logic      [2:0]                    port_mode,
	output logic      [3:0]                    fifo_threshold,
	output logic      [1:0]                    port_floppy_pin_share,
	input  wire logic [fpc_pkg::FDC_PIN_W-1:0] fdc_core_out,
	output logic      [fpc_pkg::FDC_PIN_W-1:0] fdc_pad_out,
	output logic      [fpc_pkg::FDC_PIN_W-1:0] fdc_pad_oe_n,
	output logic      [fpc_pkg::FDC_PIN_W-1:0] port_fdc_out,
	output logic                               port_fdc_oe_n,
	input  wire logic                          drive0_select_n,
	input  wire logic                          write_protect_in_n,
	input  wire logic                          port_write_protect_n,
	output logic                               core_write_protect_n,
	input  wire logic                          density_core,
	output logic                               density_out,
	input  wire logic                          ack_in_n,
	input  wire logic [2:0]                    ecr_mode,
	input  wire logic                          port_core_irq,
	output logic                               port_irq_out,
	output logic                               port_irq_oe_n
);

	fpc_pkg::fpc_state_t          state_reg;
	fpc_pkg::fpc_state_t          state_next;
	logic [fpc_pkg::SYNC_W-1:0]   pins_sync;
	logic                         wp_pin_n;
	logic                         wp_port_n;
	logic                         ack_n;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	fpc_sync u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.async_in ({ack_in_n, port_write_protect_n, write_protect_in_n}),
		.sync_out (pins_sync)
	);

	assign wp_pin_n  = pins_sync[0];
	assign wp_port_n = pins_sync[1];
	assign ack_n     = pins_sync[2];

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------

	// Field views of the stored registers
	logic       fld_tristate;
	logic       fld_push_pull;
	logic       fld_force_wp;
	logic [1:0] fld_density;
	logic [2:0] fld_pmode;
	logic       fld_pulse;
	logic [1:0] fld_share;

	assign fld_tristate  = state_reg.regs.fdc_mode[fpc_pkg::FM_TRISTATE];
	assign fld_push_pull = state_reg.regs.fdc_mode[fpc_pkg::FM_PUSH_PULL];
	assign fld_force_wp  = state_reg.regs.fdc_option[fpc_pkg::FO_FORCE_WP];
	assign fld_density   = state_reg.regs.fdc_option[fpc_pkg::FO_DENS_LO +: 2];
	assign fld_pmode     = state_reg.regs.pp_mode[fpc_pkg::PM_MODE_LO +: 3];
	assign fld_pulse     = state_reg.regs.pp_mode[fpc_pkg::PM_IRQ_PULSE];
	assign fld_share     = state_reg.regs.pp_share[fpc_pkg::PS_SHARE_LO +: 2];

	always_comb begin
		logic       ldn_fdc;
		logic       ldn_pp;
		logic       data_wr;
		logic       data_rd;
		logic [7:0] rd_value;
		logic       ecp_family;
		logic       irq_level_src;
		logic       irq_src;
		logic       irq_src_prev;
		logic       irq_event;
		logic       drive0_on_port;
		logic       any_on_port;
		state_next     = state_reg;
		ldn_fdc        = (cfg_ldn == fpc_pkg::LDN_FLOPPY);
		ldn_pp         = (cfg_ldn == fpc_pkg::LDN_PARALLEL);
		data_wr        = cfg_sel && cfg_wr && cfg_addr;
		data_rd        = cfg_sel && cfg_rd && cfg_addr;
		rd_value       = fpc_pkg::READ_ZERO;
		ecp_family     = 1'b0;
		irq_level_src  = 1'b0;
		irq_src        = 1'b0;
		irq_src_prev   = 1'b0;
		irq_event      = 1'b0;
		drive0_on_port = 1'b0;
		any_on_port    = 1'b0;

		// Index port; soft reset only clears the pointer, never the bank
		if (soft_reset) begin
			state_next.index = fpc_pkg::RST_INDEX;
		end else if (cfg_sel && cfg_wr && !cfg_addr) begin
			state_next.index = cfg_wdata;
		end

		// Data port writes, masked so fixed-zero bits never store
		if (data_wr && ldn_fdc) begin
			unique case (state_reg.index)
				fpc_pkg::IDX_FDC_MODE: begin
					state_next.regs.fdc_mode = cfg_wdata & fpc_pkg::MASK_FDC_MODE;
				end
				fpc_pkg::IDX_FDC_OPTION: begin
					state_next.regs.fdc_option = cfg_wdata;
				end
				fpc_pkg::IDX_FDC_TYPES: begin
					state_next.regs.fdc_types = cfg_wdata;
				end
				fpc_pkg::IDX_DRIVE0: begin
					state_next.regs.drive0 = cfg_wdata & fpc_pkg::MASK_DRIVE;
				end
				fpc_pkg::IDX_DRIVE1: begin
					state_next.regs.drive1 = cfg_wdata & fpc_pkg::MASK_DRIVE;
				end
				default: begin
					state_next.regs = state_reg.regs;
				end
			endcase
		end else if (data_wr && ldn_pp) begin
			unique case (state_reg.index)
				fpc_pkg::IDX_PP_MODE: begin
					state_next.regs.pp_mode = cfg_wdata & fpc_pkg::MASK_ALL;
				end
				fpc_pkg::IDX_PP_SHARE: begin
					state_next.regs.pp_share = cfg_wdata & fpc_pkg::MASK_PP_SHARE;
				end
				default: begin
					state_next.regs = state_reg.regs;
				end
			endcase
		end

		// Read mux; unmapped indices and other devices answer zero
		if (ldn_fdc) begin
			unique case (state_reg.index)
				fpc_pkg::IDX_FDC_MODE:   rd_value = state_reg.regs.fdc_mode;
				fpc_pkg::IDX_FDC_OPTION: rd_value = state_reg.regs.fdc_option;
				fpc_pkg::IDX_FDC_TYPES:  rd_value = state_reg.regs.fdc_types;
				fpc_pkg::IDX_FDC_RSVD:   rd_value = fpc_pkg::READ_ZERO;
				fpc_pkg::IDX_DRIVE0:     rd_value = state_reg.regs.drive0;
				fpc_pkg::IDX_DRIVE1:     rd_value = state_reg.regs.drive1;
				default:                 rd_value = fpc_pkg::READ_ZERO;
			endcase
		end else if (ldn_pp) begin
			unique case (state_reg.index)
				fpc_pkg::IDX_PP_MODE:  rd_value = state_reg.regs.pp_mode;
				fpc_pkg::IDX_PP_SHARE: rd_value = state_reg.regs.pp_share;
				default:               rd_value = fpc_pkg::READ_ZERO;
			endcase
		end
		if (cfg_sel && cfg_rd && !cfg_addr) begin
			state_next.rdata = state_reg.index;
		end else if (data_rd) begin
			state_next.rdata = rd_value;
		end

		// Pin sharing decode; code 3 treated as normal port
		drive0_on_port = (fld_share == fpc_pkg::SHARE_BOTH);
		any_on_port    = (fld_share == fpc_pkg::SHARE_DRIVE1) || drive0_on_port;

		// Dedicated floppy pads; open drain only ever pulls low
		for (int i = 0; i < fpc_pkg::FDC_PIN_W; i++) begin
			if (fld_tristate) begin
				state_next.pad_out[i]  = 1'b0;
				state_next.pad_oe_n[i] = 1'b1;
			end else if (fld_push_pull) begin
				state_next.pad_out[i]  = fdc_core_out[i];
				state_next.pad_oe_n[i] = 1'b0;
			end else begin
				state_next.pad_out[i]  = 1'b0;
				state_next.pad_oe_n[i] = fdc_core_out[i];
			end
		end

		// Port-pin floppy path ignores output type and tri-state
		state_next.port_fdc_out  = fdc_core_out;
		state_next.port_fdc_oe_n = !any_on_port;

		// Write protect from whichever pins carry drive 0
		state_next.core_wp_n = (drive0_on_port ? wp_port_n : wp_pin_n)
			&& !(fld_force_wp && !drive0_select_n);

		// Density override
		unique case (fld_density)
			fpc_pkg::DENS_FORCE_ONE:  state_next.density_out = 1'b1;
			fpc_pkg::DENS_FORCE_ZERO: state_next.density_out = 1'b0;
			default:                  state_next.density_out = density_core;
		endcase

		// Interrupt source selection
		ecp_family = (fld_pmode == fpc_pkg::PPM_ECP) || (fld_pmode == fpc_pkg::PPM_ECP_EPP19)
			|| (fld_pmode == fpc_pkg::PPM_ECP_EPP17);
		irq_level_src = ecp_family && ((ecr_mode == fpc_pkg::ECR_ECP)
			|| (ecr_mode == fpc_pkg::ECR_TEST) || (ecr_mode == fpc_pkg::ECR_FIFO));
		irq_src      = irq_level_src ? port_core_irq : !ack_n;
		irq_src_prev = irq_level_src ? state_reg.core_irq_prev : !state_reg.ack_n_prev;
		irq_event    = irq_src && !irq_src_prev;
		state_next.ack_n_prev    = ack_n;
		state_next.core_irq_prev = port_core_irq;

		// Pulse type honoured only outside printer and SPP modes
		if (fld_pulse && (fld_pmode != fpc_pkg::PPM_PRINTER)
			&& (fld_pmode != fpc_pkg::PPM_SPP)) begin
			unique case (state_reg.irq_state)
				fpc_pkg::IRQ_IDLE: begin
					state_next.irq_out  = 1'b0;
					state_next.irq_oe_n = !irq_event;
					state_next.irq_count = 8'(fpc_pkg::IRQ_PULSE_CYC - 1);
					if (irq_event) begin
						state_next.irq_state = fpc_pkg::IRQ_PULSE;
					end
				end
				fpc_pkg::IRQ_PULSE: begin
					state_next.irq_out  = 1'b0;
					state_next.irq_count = state_reg.irq_count - 8'h01;
					if (state_reg.irq_count == 8'h00) begin
						state_next.irq_oe_n  = 1'b1;
						state_next.irq_state = fpc_pkg::IRQ_IDLE;
					end else begin
						state_next.irq_oe_n = 1'b0;
					end
				end
			endcase
		end else begin
			state_next.irq_state = fpc_pkg::IRQ_IDLE;
			state_next.irq_count = 8'h00;
			state_next.irq_out   = irq_src;
			state_next.irq_oe_n  = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// State register: hard reset is the only path to the bank defaults
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg.index              <= fpc_pkg::RST_INDEX;
			state_reg.regs.fdc_mode      <= fpc_pkg::RST_FDC_MODE;
			state_reg.regs.fdc_option    <= fpc_pkg::RST_FDC_OPTION;
			state_reg.regs.fdc_types     <= fpc_pkg::RST_FDC_TYPES;
			state_reg.regs.drive0        <= fpc_pkg::RST_DRIVE;
			state_reg.regs.drive1        <= fpc_pkg::RST_DRIVE;
			state_reg.regs.pp_mode       <= fpc_pkg::RST_PP_MODE;
			state_reg.regs.pp_share      <= fpc_pkg::RST_PP_SHARE;
			state_reg.rdata              <= fpc_pkg::READ_ZERO;
			state_reg.ack_n_prev         <= 1'b1;
			state_reg.core_irq_prev      <= 1'b0;
			state_reg.irq_state          <= fpc_pkg::IRQ_IDLE;
			state_reg.irq_count          <= 8'h00;
			state_reg.irq_out            <= 1'b0;
			state_reg.irq_oe_n           <= 1'b0;
			state_reg.pad_out            <= '0;
			state_reg.pad_oe_n           <= '1;
			state_reg.port_fdc_out       <= '0;
			state_reg.port_fdc_oe_n      <= 1'b1;
			state_reg.core_wp_n          <= 1'b1;
			state_reg.density_out        <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all taken from the state register
	// ------------------------------------------------------------------
	assign cfg_rdata              = state_reg.rdata;
	assign enhanced_mode          = state_reg.regs.fdc_mode[fpc_pkg::FM_ENHANCED];
	assign burst_dma_en           = !state_reg.regs.fdc_mode[fpc_pkg::FM_NONBURST];
	assign host_if_mode           = state_reg.regs.fdc_mode[fpc_pkg::FM_IF_LO +: 2];
	assign drive_type_code        = state_reg.regs.fdc_types;
	assign drive0_type_select     = state_reg.regs.drive0[fpc_pkg::DP_TYPE_LO +: 2];
	assign drive0_rate_table      = state_reg.regs.drive0[fpc_pkg::DP_RATE_LO +: 2];
	assign drive0_precomp_disable = state_reg.regs.drive0[fpc_pkg::DP_PRECOMP];
	assign drive1_type_select     = state_reg.regs.drive1[fpc_pkg::DP_TYPE_LO +: 2];
	assign drive1_rate_table      = state_reg.regs.drive1[fpc_pkg::DP_RATE_LO +: 2];
	assign drive1_precomp_disable = state_reg.regs.drive1[fpc_pkg::DP_PRECOMP];
	assign port_mode              = fld_pmode;
	assign fifo_threshold         = state_reg.regs.pp_mode[fpc_pkg::PM_THRESH_LO +: 4];
	assign port_floppy_pin_share  = fld_share;
	assign fdc_pad_out            = state_reg.pad_out;
	assign fdc_pad_oe_n           = state_reg.pad_oe_n;
	assign port_fdc_out           = state_reg.port_fdc_out;
	assign port_fdc_oe_n          = state_reg.port_fdc_oe_n;
	assign core_write_protect_n   = state_reg.core_wp_n;
	assign density_out            = state_reg.density_out;
	assign port_irq_out           = state_reg.irq_out;
	assign port_irq_oe_n          = state_reg.irq_oe_n;

endmodule : fpc_config_regs

// [fpc_cr_assertions.sv]
// Port checker for the floppy/port configuration register bank.
// Assumes a bind from the bench top and a single clock domain.
`timescale 1ns/1ps

module fpc_cr_assertions (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       soft_reset,
	input wire logic       cfg_sel,
	input wire logic       cfg_addr,
	input wire logic       cfg_wr,
	input wire logic       cfg_rd,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_ldn,
	input wire logic [7:0] cfg_rdata,
	input wire logic       enhanced_mode,
	input wire logic       burst_dma_en,
	input wire logic [1:0] host_if_mode,
	input wire logic [7:0] drive_type_code,
	input wire logic [2:0] port_mode,
	input wire logic [3:0] fifo_threshold,
	input wire logic       port_irq_out,
	input wire logic       port_irq_oe_n
);
	// ----
	// Shadow index, since the bank keeps its pointer hidden
	// ----
	logic [7:0] idx_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) idx_reg <= 8'h00;
		else if (soft_reset) idx_reg <= 8'h00;
		else if (cfg_sel && cfg_wr && !cfg_addr) idx_reg <= cfg_wdata;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_wr(logic [7:0] i, logic [7:0] l);
		cfg_sel && cfg_wr && cfg_addr && idx_reg == i && cfg_ldn == l;
	endsequence
	sequence s_rd(logic [7:0] i);
		cfg_sel && cfg_rd && cfg_addr && idx_reg == i && cfg_ldn == 8'h00;
	endsequence

	a_soft_keeps_regs: assert property (soft_reset && !cfg_wr |=> $stable({enhanced_mode, port_mode}))
		else $error("setting moved on soft reset");
	a_enh_mode_bit: assert property (s_wr(8'hf0, 8'h00) |=> enhanced_mode == $past(cfg_wdata[0]))
		else $error("enhanced mode wrong");
	a_dma_style_bit: assert property (s_wr(8'hf0, 8'h00) |=> burst_dma_en == !$past(cfg_wdata[1]))
		else $error("dma style wrong");
	a_host_if_field: assert property (s_wr(8'hf0, 8'h00) |=> host_if_mode == $past(cfg_wdata[3:2]))
		else $error("host interface mode wrong");
	a_type_codes: assert property (s_wr(8'hf2, 8'h00) |=> drive_type_code == $past(cfg_wdata))
		else $error("drive type codes wrong");
	a_port_mode_fields: assert property (s_wr(8'hf0, 8'h03) |=> {fifo_threshold, port_mode} == $past(cfg_wdata[6:0]))
		else $error("port mode fields wrong");
	a_f3_reads_zero: assert property (s_rd(8'hf3) |=> cfg_rdata == 8'h00)
		else $error("reserved index not zero");
	a_drive_zero_bits: assert property (s_rd(8'hf4) |=> (cfg_rdata & 8'ha4) == 8'h00)
		else $error("drive reserved bits set");
	a_irq_pulse_low: assert property ($fell(port_irq_oe_n) && !port_irq_out |=> (!port_irq_oe_n)[*8])
		else $error("interrupt pulse too short");
endmodule : fpc_cr_assertions

// [fpc_host.sv]
// Behavioural host on the index/data configuration port.
// Assumes the bench calls acc; signals move on falling edges.
`timescale 1ns/1ps

module fpc_host (
	input  wire logic       clk,
	output logic            cfg_sel,
	output logic            cfg_addr,
	output logic            cfg_wr,
	output logic            cfg_rd,
	output logic      [7:0] cfg_wdata
);
	initial begin
		{cfg_sel, cfg_addr, cfg_wr, cfg_rd, cfg_wdata} = 12'h000;
	end

	// One strobe cycle; released bus shows inverted junk, not old data
	task acc(input logic w, input logic a, input logic [7:0] d);
		@(negedge clk);
		{cfg_sel, cfg_addr, cfg_wr, cfg_rd} = {1'b1, a, w, !w};
		cfg_wdata = d;
		@(negedge clk);
		{cfg_sel, cfg_addr, cfg_wr, cfg_rd} = {1'b0, !a, 2'b00};
		cfg_wdata = ~d;
	endtask : acc
endmodule : fpc_host

// [tb_top.sv]
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the port; read answers are queued.
`timescale 1ns/1ps

module tb_top;
	logic        clk, rstn, soft_reset, cfg_sel, cfg_addr, cfg_wr, cfg_rd, enhanced_mode, burst_dma_en;
	logic        port_fdc_oe_n, drive0_select_n, write_protect_in_n, core_write_protect_n, density_core;
	logic        density_out, ack_in_n, port_irq_out, port_irq_oe_n;
	logic        port_write_protect_n, port_core_irq, drive0_precomp_disable, drive1_precomp_disable;
	logic [1:0]  host_if_mode, port_floppy_pin_share;
	logic [1:0]  drive0_type_select, drive0_rate_table, drive1_type_select, drive1_rate_table;
	logic [2:0]  port_mode, ecr_mode;
	logic [7:0]  port_fdc_out;
	logic [3:0]  fifo_threshold;
	logic [7:0]  cfg_wdata, cfg_ldn, cfg_rdata, drive_type_code, fdc_core_out, fdc_pad_out, fdc_pad_oe_n;
	logic [7:0]  expq[$], sv[9];
	logic [31:0] lf = 32'h77ba_397c;
	logic        rd_d = 1'b0;
	int          n_checks = 0, n_mismatch = 0;
	localparam logic [7:0] TL [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00};
	localparam logic [7:0] TI [9] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf0, 8'hf1, 8'hf6};
	localparam logic [7:0] TR [9] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00};
	localparam logic [7:0] TM [9] = '{8'hdf, 8'hff, 8'hff, 8'h00, 8'h5b, 8'h5b, 8'hff, 8'h03, 8'h00};

	fpc_host u_host (.clk, .cfg_sel, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata);
	fpc_config_regs u_fpc_config_regs (.clk, .rstn, .soft_reset, .cfg_sel, .cfg_addr, .cfg_wr, .cfg_rd,
		.cfg_wdata, .cfg_ldn, .cfg_rdata, .enhanced_mode, .burst_dma_en, .host_if_mode, .drive_type_code,
		.drive0_type_select, .drive0_rate_table, .drive0_precomp_disable, .drive1_type_select,
		.drive1_rate_table, .drive1_precomp_disable, .port_mode, .fifo_threshold, .port_floppy_pin_share,
		.fdc_core_out, .fdc_pad_out, .fdc_pad_oe_n, .port_fdc_out, .port_fdc_oe_n, .drive0_select_n,
		.write_protect_in_n, .port_write_protect_n, .core_write_protect_n, .density_core, .density_out,
		.ack_in_n, .ecr_mode, .port_core_irq, .port_irq_out, .port_irq_oe_n);

	// ----
	// Clock, watchdog and read monitor
	// ----
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		n_mismatch++;
		give_verdict();
	end
	// Answers land one edge after the strobe, so look on the next fall
	always @(posedge clk) rd_d <= cfg_sel && cfg_rd;
	always @(negedge clk) begin
		if (rd_d) chk(cfg_rdata, expq.pop_front());
	end

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wreg(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
		cfg_ldn = l;
		u_host.acc(1'b1, 1'b0, i);
		u_host.acc(1'b1, 1'b1, d);
	endtask : wreg
	task rexp(input logic [7:0] l, input logic [7:0] i, input logic [7:0] e);
		cfg_ldn = l;
		u_host.acc(1'b1, 1'b0, i);
		expq.push_back(e);
		u_host.acc(1'b0, 1'b1, 8'h00);
	endtask : rexp
	task rd_all(input logic def);
		for (int k = 0; k < 9; k++) rexp(TL[k], TI[k], def ? TR[k] : sv[k]);
	endtask : rd_all
	// Waits only; the caller samples afterwards, so values are fresh
	task settle();
		repeat (4) @(negedge clk);
	endtask : settle
	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ----
	// Main sequence: defaults, random fill, soft and hard resets, pins
	// ----
	initial begin
		{rstn, soft_reset, drive0_select_n, write_protect_in_n, ack_in_n, density_core} = 6'h0e;
		{cfg_ldn, fdc_core_out, ecr_mode, port_core_irq, port_write_protect_n} = 21'h0_0005;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		rd_all(1'b1);
		for (int k = 0; k < 9; k++) begin
			lf = nx(lf);
			sv[k] = lf[7:0] & TM[k];
			wreg(TL[k], TI[k], lf[7:0]);
		end
		rd_all(1'b0);
		chk({1'b0, drive0_precomp_disable, 1'b0, drive0_rate_table, 1'b0, drive0_type_select}, sv[4]);
		chk({1'b0, drive1_precomp_disable, 1'b0, drive1_rate_table, 1'b0, drive1_type_select}, sv[5]);
		chk({6'h00, port_floppy_pin_share}, sv[7]);
		soft_reset = 1'b1;
		@(negedge clk) soft_reset = 1'b0;
		expq.push_back(8'h00);
		u_host.acc(1'b0, 1'b0, 8'h00);
		rd_all(1'b0);
		wreg(8'h03, 8'hf1, 8'h01);
		wreg(8'h00, 8'hf0, 8'h80);
		settle();
		chk(fdc_pad_oe_n, 8'hff);
		chk({7'h00, port_fdc_oe_n}, 8'h00);
		lf = nx(lf);
		fdc_core_out = lf[15:8];
		wreg(8'h00, 8'hf0, 8'h40);
		settle();
		chk(fdc_pad_out, fdc_core_out);
		chk(port_fdc_out, fdc_core_out);
		wreg(8'h00, 8'hf0, 8'h00);
		settle();
		chk(fdc_pad_oe_n, fdc_core_out);
		wreg(8'h03, 8'hf1, 8'h02);
		wreg(8'h00, 8'hf1, 8'h09);
		drive0_select_n = 1'b0;
		settle();
		chk({6'h00, core_write_protect_n, density_out}, 8'h01);
		density_core = 1'b1;
		port_write_protect_n = 1'b0;
		wreg(8'h00, 8'hf1, 8'h0c);
		settle();
		chk({6'h00, core_write_protect_n, density_out}, 8'h00);
		// Pulse type in an EPP mode, so acknowledge is the source
		wreg(8'h03, 8'hf0, 8'hb9);
		@(negedge clk) ack_in_n = 1'b0;
		for (int k = 0; k < 8 && port_irq_oe_n !== 1'b0; k++) @(negedge clk);
		repeat (9) @(negedge clk);
		chk({7'h00, port_irq_oe_n}, 8'h00);
		@(negedge clk) chk({7'h00, port_irq_oe_n}, 8'h01);
		wreg(8'h03, 8'hf0, 8'hbc);
		settle();
		chk({6'h00, port_irq_out, port_irq_oe_n}, 8'h02);
		wreg(8'h03, 8'hf0, 8'h3a);
		settle();
		chk({6'h00, port_irq_out, port_irq_oe_n}, 8'h02);
		ecr_mode = 3'h3;
		settle();
		chk({6'h00, port_irq_out, port_irq_oe_n}, 8'h00);
		port_core_irq = 1'b1;
		settle();
		chk({6'h00, port_irq_out, port_irq_oe_n}, 8'h02);
		rstn = 1'b0;
		@(negedge clk) rstn = 1'b1;
		rd_all(1'b1);
		repeat (3) @(negedge clk);
		give_verdict();
	end
endmodule : tb_top

bind fpc_config_regs fpc_cr_assertions u_chk (.clk, .rstn, .soft_reset, .cfg_sel, .cfg_addr, .cfg_wr, .cfg_rd,
	.cfg_wdata, .cfg_ldn, .cfg_rdata, .enhanced_mode, .burst_dma_en, .host_if_mode, .drive_type_code,
	.port_mode, .fifo_threshold, .port_irq_out, .port_irq_oe_n);
